// [rtl/handler_ctrl_pkg.sv]
// constants and carrier types for the system handler priority and control-status block
// How it works
// RL1 - only privileged accesses read or change registers
// RL2 - priority register accepts byte and word writes
// RL3 - priority register at D20h, resets to zero
// RL4 - bits 31:29 hold tick timer priority
// RL5 - bits 23:21 hold deferred service priority
// RL6 - bits 7:5 hold debug event priority
// RL7 - lower priority value wins arbitration
// RL8 - priority reserved bits read zero, read-only
// RL9 - control-status register at D24h, resets zero
// RL10 - bits 18:16 enable usage, bus, protection handlers
// RL11 - fault with handler disabled becomes hard fault
// RL12 - bits 15:12 show supervisor, bus, protection, usage pending
// RL13 - active flags at bits 11,10,8,7,3,1,0
// RL14 - software writes set or clear pending/active state
// RL15 - control-status reserved bits read zero, read-only
// RL16 - kernel may write active flags to switch context
// RL17 - software changing active flag fixes stacked context
// RL18 - software preserves and restores active state
// RL19 - software uses read-modify-write once handlers enabled
// RL20 - flag value one means enabled, pending or active
// RL21 - writes to reserved bits are ignored
package handler_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] PRIO_OFFSET = 12'hD20;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'hD24;
  localparam logic [31:0] PRIO_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PRIO_WMASK = 32'hE0E0_00E0;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_FD8B;
  localparam int PRIO_W = 3;
  localparam int TICK_PRIO_LSB = 29;
  localparam int DEFER_PRIO_LSB = 21;
  localparam int DEBUG_PRIO_LSB = 5;
  localparam int EN_USAGE_BIT = 18;
  localparam int EN_BUS_BIT = 17;
  localparam int EN_PROT_BIT = 16;
  localparam int PEND_LSB = 12;
  localparam int PEND_SUPV_BIT = 15;
  localparam int PEND_BUS_BIT = 14;
  localparam int PEND_PROT_BIT = 13;
  localparam int PEND_USAGE_BIT = 12;
  localparam int ACT_TICK_BIT = 11;
  localparam int ACT_DEFER_BIT = 10;
  localparam int ACT_DEBUG_BIT = 8;
  localparam int ACT_SUPV_BIT = 7;
  localparam int ACT_USAGE_BIT = 3;
  localparam int ACT_BUS_BIT = 1;
  localparam int ACT_PROT_BIT = 0;
  localparam logic [2:0] WIN_TICK = 3'h4;
  localparam logic [2:0] WIN_DEFER = 3'h2;
  localparam logic [2:0] WIN_DEBUG = 3'h1;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [2:0] pprot;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // fault_evt: {usage, bus, protection}; pend: {supv, bus, prot, usage}
  // act: {tick, defer, debug, supv, usage, bus, prot}
  typedef struct packed {
    logic [2:0] fault_evt;
    logic [3:0] pend_set;
    logic [3:0] pend_clr;
    logic [6:0] act_set;
    logic [6:0] act_clr;
  } core_evt_t;

  typedef struct packed {
    logic [31:0] prio;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic slverr;
    logic hard_fault;
    logic [2:0] win;
    logic [2:0] win_prio;
    logic win_valid;
  } state_t;
endpackage : handler_ctrl_pkg

// [rtl/prio_pick.sv]
// two-way priority comparator, lower value wins, ties keep side a
`timescale 1ns/10ps
module prio_pick #(
  parameter int W = 3
) (
  input wire logic a_valid, // candidate a present
  input wire logic [W-1:0] a_prio, // candidate a level
  input wire logic b_valid, // candidate b present
  input wire logic [W-1:0] b_prio, // candidate b level
  output logic take_b, // b beats a
  output logic out_valid, // any candidate present
  output logic [W-1:0] out_prio // level of the winner
);
  always_comb begin
    take_b = b_valid & (~a_valid | (b_prio < a_prio)); // RL7
    out_valid = a_valid | b_valid;
    out_prio = take_b ? b_prio : a_prio;
  end
endmodule : prio_pick

// [rtl/system_handler_prio_ctrl.sv]
// system handler priority and control-status registers with apb slave and arbiter
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module system_handler_prio_ctrl (
  input wire logic CLK_SYS, // system clock
  input wire logic RST, // synchronous reset, active high
  input wire logic CE, // clock enable, freezes state when low
  input wire handler_ctrl_pkg::apb_req_t APB_REQ, // apb request
  output handler_ctrl_pkg::apb_rsp_t APB_RSP, // apb response
  input wire handler_ctrl_pkg::core_evt_t CORE_EVT, // core exception events
  input wire logic [2:0] EXC_REQ, // {tick, defer, debug} requests
  output logic HARD_FAULT, // escalated fault pulse
  output logic [2:0] FAULT_ENABLE, // {usage, bus, prot} enables
  output logic [3:0] PENDING, // {supv, bus, prot, usage} pending
  output logic [6:0] ACTIVE, // {tick, defer, debug, supv, usage, bus, prot}
  output logic [2:0] WIN, // one-hot arbitration winner
  output logic [2:0] WIN_PRIO, // level of the winner
  output logic WIN_VALID // a winner exists
);
  import handler_ctrl_pkg::*;

  state_t st_reg;
  state_t st_next;
  logic setup;
  logic access;
  logic priv;
  logic hit_prio;
  logic hit_ctrl;
  logic [2:0] tick_prio;
  logic [2:0] defer_prio;
  logic [2:0] debug_prio;
  logic s1_take_b;
  logic s1_valid;
  logic [2:0] s1_prio;
  logic s2_take_b;
  logic s2_valid;
  logic [2:0] s2_prio;

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_val & ~m) | (wdata & m);
  endfunction : lane_merge

  // scatter the seven active flags onto their word positions
  function automatic logic [31:0] act_word(input logic [6:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ACT_TICK_BIT] = v[6];
    w[ACT_DEFER_BIT] = v[5];
    w[ACT_DEBUG_BIT] = v[4];
    w[ACT_SUPV_BIT] = v[3];
    w[ACT_USAGE_BIT] = v[2];
    w[ACT_BUS_BIT] = v[1];
    w[ACT_PROT_BIT] = v[0];
    return w;
  endfunction : act_word

  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign priv = APB_REQ.pprot[0];
  assign hit_prio = APB_REQ.paddr[ADDR_W-1:2] == PRIO_OFFSET[ADDR_W-1:2];
  assign hit_ctrl = APB_REQ.paddr[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2];
  assign tick_prio = st_reg.prio[TICK_PRIO_LSB +: PRIO_W]; // RL4
  assign defer_prio = st_reg.prio[DEFER_PRIO_LSB +: PRIO_W]; // RL5
  assign debug_prio = st_reg.prio[DEBUG_PRIO_LSB +: PRIO_W]; // RL6

  prio_pick #(.W(PRIO_W)) u_pick_first (
    .a_valid(EXC_REQ[2]),
    .a_prio(tick_prio),
    .b_valid(EXC_REQ[1]),
    .b_prio(defer_prio),
    .take_b(s1_take_b),
    .out_valid(s1_valid),
    .out_prio(s1_prio)
  );

  prio_pick #(.W(PRIO_W)) u_pick_second (
    .a_valid(s1_valid),
    .a_prio(s1_prio),
    .b_valid(EXC_REQ[0]),
    .b_prio(debug_prio),
    .take_b(s2_take_b),
    .out_valid(s2_valid),
    .out_prio(s2_prio)
  );

  always_comb begin
    st_next = st_reg;
    st_next.hard_fault = 1'b0;
    // read data is latched in the setup cycle so prdata comes from a flop
    if (setup) begin
      st_next.rdata = 32'h0000_0000;
      st_next.slverr = 1'b0;
      if (!priv) begin
        st_next.slverr = 1'b1; // RL1
      end else if (hit_prio) begin
        st_next.rdata = st_reg.prio & PRIO_WMASK; // RL8
      end else if (hit_ctrl) begin
        st_next.rdata = st_reg.ctrl & CTRL_WMASK; // RL15
      end else begin
        st_next.slverr = 1'b1;
      end
    end
    if (access && APB_REQ.pwrite && priv) begin // RL1
      if (hit_prio) begin
        st_next.prio = lane_merge(st_reg.prio, APB_REQ.pwdata, APB_REQ.pstrb, PRIO_WMASK); // RL2
      end else if (hit_ctrl) begin
        st_next.ctrl = lane_merge(st_reg.ctrl, APB_REQ.pwdata, APB_REQ.pstrb, CTRL_WMASK); // RL14
      end
    end
    // core clears first, then sets, so an event in the clearing cycle survives
    st_next.ctrl[PEND_LSB +: 4] = st_next.ctrl[PEND_LSB +: 4] & ~CORE_EVT.pend_clr;
    st_next.ctrl[PEND_LSB +: 4] = st_next.ctrl[PEND_LSB +: 4] | CORE_EVT.pend_set; // RL12
    st_next.ctrl = st_next.ctrl & ~act_word(CORE_EVT.act_clr);
    st_next.ctrl = st_next.ctrl | act_word(CORE_EVT.act_set); // RL13
    if (CORE_EVT.fault_evt[2]) begin
      if (st_reg.ctrl[EN_USAGE_BIT]) begin // RL10
        st_next.ctrl[PEND_USAGE_BIT] = 1'b1; // RL20
      end else begin
        st_next.hard_fault = 1'b1; // RL11
      end
    end
    if (CORE_EVT.fault_evt[1]) begin
      if (st_reg.ctrl[EN_BUS_BIT]) begin
        st_next.ctrl[PEND_BUS_BIT] = 1'b1;
      end else begin
        st_next.hard_fault = 1'b1; // RL11
      end
    end
    if (CORE_EVT.fault_evt[0]) begin
      if (st_reg.ctrl[EN_PROT_BIT]) begin
        st_next.ctrl[PEND_PROT_BIT] = 1'b1;
      end else begin
        st_next.hard_fault = 1'b1; // RL11
      end
    end
    // reserved positions never hold a one, whatever the write carried
    st_next.prio = st_next.prio & PRIO_WMASK; // RL21
    st_next.ctrl = st_next.ctrl & CTRL_WMASK; // RL21
    st_next.win_valid = s2_valid;
    st_next.win_prio = s2_prio;
    if (!s2_valid) begin
      st_next.win = 3'h0;
    end else if (s2_take_b) begin
      st_next.win = WIN_DEBUG; // RL7
    end else if (s1_take_b) begin
      st_next.win = WIN_DEFER;
    end else begin
      st_next.win = WIN_TICK;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_reg <= '0; // RL3 RL9
      st_reg.prio <= PRIO_RESET;
      st_reg.ctrl <= CTRL_RESET;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // pready follows CE so a frozen block never completes a transfer
  assign APB_RSP.pready = CE;
  assign APB_RSP.prdata = st_reg.rdata;
  assign APB_RSP.pslverr = st_reg.slverr;
  assign HARD_FAULT = st_reg.hard_fault;
  assign FAULT_ENABLE = st_reg.ctrl[EN_PROT_BIT +: 3];
  assign PENDING = st_reg.ctrl[PEND_LSB +: 4];
  assign ACTIVE = {st_reg.ctrl[ACT_TICK_BIT], st_reg.ctrl[ACT_DEFER_BIT],
                   st_reg.ctrl[ACT_DEBUG_BIT], st_reg.ctrl[ACT_SUPV_BIT],
                   st_reg.ctrl[ACT_USAGE_BIT], st_reg.ctrl[ACT_BUS_BIT],
                   st_reg.ctrl[ACT_PROT_BIT]};
  assign WIN = st_reg.win;
  assign WIN_PRIO = st_reg.win_prio;
  assign WIN_VALID = st_reg.win_valid;

  logic [31:0] prio_q;
  logic [31:0] ctrl_q;
  logic quiet_evt;
  assign prio_q = st_reg.prio;
  assign ctrl_q = st_reg.ctrl;
  assign quiet_evt = CORE_EVT == '0;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_reset_zero;
    $fell(RST) |-> (prio_q == 32'h0000_0000) && (ctrl_q == 32'h0000_0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset"); // RL3

  property p_prio_reserved;
    (prio_q & ~PRIO_WMASK) == 32'h0000_0000;
  endproperty
  a_prio_reserved: assert property (p_prio_reserved) else $error("priority reserved bit set"); // RL8

  property p_ctrl_reserved;
    (ctrl_q & ~CTRL_WMASK) == 32'h0000_0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control reserved bit set"); // RL15

  property p_unpriv_blocked;
    CE && access && APB_REQ.pwrite && !priv |=> $stable(prio_q);
  endproperty
  a_unpriv_blocked: assert property (p_unpriv_blocked) else $error("unprivileged write took effect"); // RL1

  property p_unpriv_read;
    CE && setup && !priv ##1 CE && access |-> APB_RSP.pslverr && APB_RSP.prdata == 32'h0;
  endproperty
  a_unpriv_read: assert property (p_unpriv_read) else $error("unprivileged read leaked data"); // RL1

  property p_byte_write;
    CE && access && APB_REQ.pwrite && priv && hit_prio && APB_REQ.pstrb == 4'h8
      |=> prio_q[23:0] == $past(prio_q[23:0]) && prio_q[31:29] == $past(APB_REQ.pwdata[31:29]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write on priority wrong"); // RL2

  property p_ctrl_write;
    CE && access && APB_REQ.pwrite && priv && hit_ctrl && APB_REQ.pstrb == 4'hF && quiet_evt
      |=> ctrl_q == ($past(APB_REQ.pwdata) & CTRL_WMASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied"); // RL14

  property p_escalate;
    CE && CORE_EVT.fault_evt[2] && !ctrl_q[EN_USAGE_BIT] |=> HARD_FAULT;
  endproperty
  a_escalate: assert property (p_escalate) else $error("disabled fault not escalated"); // RL11

  property p_enabled_pends;
    // a second, disabled fault in the same cycle would raise the hard fault
    CE && CORE_EVT.fault_evt == 3'b001 && ctrl_q[EN_PROT_BIT]
      |=> PENDING[1] && !HARD_FAULT ##1 1'b1;
  endproperty
  a_enabled_pends: assert property (p_enabled_pends) else $error("enabled fault not pending"); // RL10

  property p_set_wins;
    CE && CORE_EVT.pend_set[3] && CORE_EVT.pend_clr[3] |=> PENDING[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("pending set lost to clear"); // RL12

  property p_lower_wins;
    CE && EXC_REQ == 3'h3 && debug_prio < defer_prio |=> WIN == WIN_DEBUG && WIN_VALID;
  endproperty
  a_lower_wins: assert property (p_lower_wins) else $error("higher level won arbitration"); // RL7

  property p_read_ctrl;
    CE && setup && priv && hit_ctrl |=> APB_RSP.prdata == $past(ctrl_q);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control read mismatch"); // RL13

  property p_prio_read;
    CE && setup && priv && hit_prio |=> APB_RSP.prdata == $past(prio_q) && !APB_RSP.pslverr;
  endproperty
  a_prio_read: assert property (p_prio_read) else $error("priority read mismatch"); // RL4

  property p_unpriv_ctrl;
    CE && access && APB_REQ.pwrite && !priv && quiet_evt |=> $stable(ctrl_q);
  endproperty
  a_unpriv_ctrl: assert property (p_unpriv_ctrl) else $error("unprivileged control write"); // RL1

  // unmapped offsets must leave both registers untouched
  property p_unmapped_write;
    CE && access && APB_REQ.pwrite && !hit_prio && !hit_ctrl && quiet_evt
      |=> $stable(prio_q) && $stable(ctrl_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("stray write landed"); // RL21

  property p_no_false_fault;
    CE && CORE_EVT.fault_evt == 3'h0 |=> !HARD_FAULT;
  endproperty
  a_no_false_fault: assert property (p_no_false_fault) else $error("spurious hard fault"); // RL11

  property p_act_set;
    CE && CORE_EVT.act_set != 7'h00
      |=> (ACTIVE & $past(CORE_EVT.act_set)) == $past(CORE_EVT.act_set);
  endproperty
  a_act_set: assert property (p_act_set) else $error("active set lost"); // RL13

  // a core clear beats a software write in the same cycle, a core set does not lose
  property p_act_clr;
    CE && (CORE_EVT.act_clr & ~CORE_EVT.act_set) != 7'h00
      |=> (ACTIVE & $past(CORE_EVT.act_clr & ~CORE_EVT.act_set)) == 7'h00;
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("active clear lost"); // RL13

  property p_pend_clr;
    CE && (CORE_EVT.pend_clr & ~CORE_EVT.pend_set) != 4'h0 && CORE_EVT.fault_evt == 3'h0
      |=> (PENDING & $past(CORE_EVT.pend_clr & ~CORE_EVT.pend_set)) == 4'h0;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending clear lost"); // RL12

  // a low enable holds every flag, even with core events arriving
  property p_freeze;
    !CE |=> $stable(prio_q) && $stable(ctrl_q) && $stable(HARD_FAULT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // RL14

  property p_win_none;
    CE && EXC_REQ == 3'h0 |=> !WIN_VALID && WIN == 3'h0;
  endproperty
  a_win_none: assert property (p_win_none) else $error("winner without request"); // RL7

  // ties go to tick, the first candidate in the chain
  property p_tie_tick;
    CE && EXC_REQ[2] && (!EXC_REQ[1] || tick_prio <= defer_prio)
      && (!EXC_REQ[0] || tick_prio <= debug_prio)
      |=> WIN == WIN_TICK && WIN_PRIO == $past(tick_prio);
  endproperty
  a_tie_tick: assert property (p_tie_tick) else $error("tick should have won"); // RL7

  c_byte_write: cover property (CE && access && priv && hit_prio && APB_REQ.pstrb == 4'h2);
  c_hard_fault: cover property (HARD_FAULT);
  c_unpriv: cover property (CE && access && !priv);
  c_three_way: cover property (CE && EXC_REQ == 3'h7 ##1 WIN_VALID);
endmodule : system_handler_prio_ctrl

// [tb/system_handler_prio_ctrl_test.sv]
// self-checking bench for the system handler priority and control-status block
`timescale 1ns/10ps
module system_handler_prio_ctrl_test;
  import handler_ctrl_pkg::*;
  logic clk_sys;
  logic rst;
  logic ce;
  apb_req_t req;
  apb_rsp_t rsp;
  core_evt_t evt;
  logic [2:0] exc;
  logic hard_fault;
  logic [2:0] fault_enable;
  logic [3:0] pending;
  logic [6:0] active;
  logic [2:0] win;
  logic [2:0] win_prio;
  logic win_valid;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch;
  int compares;
  int cycles;

  system_handler_prio_ctrl DUT (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .CE(ce),
    .APB_REQ(req),
    .APB_RSP(rsp),
    .CORE_EVT(evt),
    .EXC_REQ(exc),
    .HARD_FAULT(hard_fault),
    .FAULT_ENABLE(fault_enable),
    .PENDING(pending),
    .ACTIVE(active),
    .WIN(win),
    .WIN_PRIO(win_prio),
    .WIN_VALID(win_valid)
  );

  task conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen high at an edge
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
            input logic p);
    @(posedge clk_sys);
    req <= '{a, 1'b1, 1'b0, w, d, s, {2'b00, p}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // no wait-state count assumed; only the bench timeout ends a hang
    @(posedge clk_sys);
    while (rsp.pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic p);
    xfer(a, 1'b1, d, s, p);
    #1;
  endtask : wr

  task rd(input logic [11:0] a, input logic p);
    xfer(a, 1'b0, 32'h0000_0000, 4'h0, p);
  endtask : rd

  // core event held for exactly one edge
  task pulse(input core_evt_t e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
    #1;
  endtask : pulse

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    evt = '0;
    exc = 3'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'hD20, 1'b1);
    check(rdat, 32'h0000_0000);
    rd(12'hD24, 1'b1);
    check(rdat, 32'h0000_0000);
    $display("test reset_values done");
    wr(12'hD20, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd(12'hD20, 1'b1);
    check(rdat, 32'hE0E0_00E0);
    wr(12'hD20, 32'h0000_0000, 4'h1, 1'b1);
    rd(12'hD20, 1'b1);
    check(rdat, 32'hE0E0_0000);
    $display("test priority_fields done");
    // unprivileged write then read must be refused
    wr(12'hD20, 32'h0000_0000, 4'hF, 1'b0);
    check({31'h0, rerr}, 32'h1);
    rd(12'hD20, 1'b0);
    check({31'h0, rerr}, 32'h1);
    check(rdat, 32'h0000_0000);
    wr(12'hD28, 32'hFFFF_FFFF, 4'hF, 1'b1);
    rd(12'hD20, 1'b1);
    check(rdat, 32'hE0E0_0000);
    $display("test privilege done");
    wr(12'hD24, 32'hFFFF_FFFF, 4'hF, 1'b1);
    check({29'h0, fault_enable}, 32'h7);
    check({28'h0, pending}, 32'hF);
    check({25'h0, active}, 32'h7F);
    rd(12'hD24, 1'b1);
    check(rdat, 32'h0007_FD8B);
    wr(12'hD24, 32'h0001_0000, 4'hF, 1'b1);
    check({25'h0, active}, 32'h0);
    $display("test control_status done");
    // only the protection handler is enabled until the bus handler is added
    pulse('{fault_evt: 3'b001, default: '0});
    check({28'h0, pending}, 32'h2);
    check({31'h0, hard_fault}, 32'h0);
    pulse('{fault_evt: 3'b010, default: '0});
    check({31'h0, hard_fault}, 32'h1);
    @(posedge clk_sys);
    #1;
    check({31'h0, hard_fault}, 32'h0);
    pulse('{act_set: 7'b100_0000, default: '0});
    rd(12'hD24, 1'b1);
    check(rdat, 32'h0001_2800);
    // enable the bus handler by read-modify-write, keeping the active tick
    wr(12'hD24, rdat | 32'h0002_0000, 4'hF, 1'b1);
    check({29'h0, fault_enable}, 32'h3);
    check({25'h0, active}, 32'h40);
    // kernel-style context switch from tick to deferred service
    rd(12'hD24, 1'b1);
    wr(12'hD24, (rdat & ~32'h0000_0800) | 32'h0000_0400, 4'hF, 1'b1);
    check({25'h0, active}, 32'h20);
    pulse('{act_clr: 7'b010_0000, pend_set: 4'h8, pend_clr: 4'hA, default: '0});
    check({25'h0, active}, 32'h0);
    check({28'h0, pending}, 32'h8);
    wr(12'hD24, 32'h0000_0000, 4'hF, 1'b1);
    check({18'h0, fault_enable, pending, active}, 32'h0);
    $display("test fault_escalation done");
    // tick 5, deferred 2, debug 6
    wr(12'hD20, 32'hA040_00C0, 4'hF, 1'b1);
    @(posedge clk_sys);
    exc <= 3'b111;
    @(posedge clk_sys);
    #1;
    check({25'h0, win_valid, win, win_prio}, {25'h0, 7'b1_010_010});
    @(posedge clk_sys);
    exc <= 3'b101;
    @(posedge clk_sys);
    #1;
    check({25'h0, win_valid, win, win_prio}, {25'h0, 7'b1_100_101});
    @(posedge clk_sys);
    exc <= 3'b000;
    // debug one level under deferred, then tick tied with deferred
    wr(12'hD20, 32'h0000_0020, 4'h1, 1'b1);
    wr(12'hD20, 32'h4000_0000, 4'h8, 1'b1);
    rd(12'hD20, 1'b1);
    check(rdat, 32'h4040_0020);
    @(posedge clk_sys);
    exc <= 3'b011;
    @(posedge clk_sys);
    #1;
    check({25'h0, win_valid, win, win_prio}, {25'h0, 7'b1_001_001});
    @(posedge clk_sys);
    exc <= 3'b110;
    @(posedge clk_sys);
    #1;
    check({25'h0, win_valid, win, win_prio}, {25'h0, 7'b1_100_010});
    @(posedge clk_sys);
    exc <= 3'b000;
    @(posedge clk_sys);
    #1;
    check({31'h0, win_valid}, 32'h0);
    $display("test arbitration done");
    // events arriving while the enable is low are lost, not queued
    @(posedge clk_sys);
    ce <= 1'b0;
    evt <= '{pend_set: 4'hF, fault_evt: 3'h7, default: '0};
    repeat (2) @(posedge clk_sys);
    ce <= 1'b1;
    evt <= '0;
    #1;
    check({27'h0, hard_fault, pending}, 32'h0);
    $display("test clock_enable done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'hD20, 1'b1);
    check(rdat, 32'h0000_0000);
    $display("test mid_reset done");
    conclude();
  end
endmodule : system_handler_prio_ctrl_test
